// file: inc/stepper_consts.svh
// constants for the stepper phase sequencer: offsets, fields, resets, codes, timing
`ifndef STEPPER_CONSTS_SVH
`define STEPPER_CONSTS_SVH

`define CLK_HZ 125000000
`define MODE_SETUP_NS 5000
`define MODE_SETUP_CYC ((`MODE_SETUP_NS * (`CLK_HZ / 1000000) + 999) / 1000)

`define AXI_AW 8
`define REG_STATUS 8'h00
`define REG_IRQ_STAT 8'h04
`define REG_IRQ_MASK 8'h08
`define REG_STEP_CNT 8'h0C

`define ST_POS_LSB 0
`define ST_FAULT 3
`define ST_KIND_LSB 4
`define ST_ENABLE 6
`define ST_RESET 7
`define ST_PIN 8

`define IRQ_STEP 0
`define IRQ_FAULT 1
`define IRQ_RELEASE 2
`define IRQ_W 3
`define IRQ_MASK_RST 3'h0

`define POS_INIT 3'h0
`define INIT_WIND 4'h9
`define WIND_W1P 0
`define WIND_W1N 1
`define WIND_W2P 2
`define WIND_W2N 3

`define KIND_NONE 2'h0
`define KIND_OPEN 2'h1
`define KIND_OVERCUR 2'h2
`define KIND_OVERHEAT 2'h3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define STEP_CNT_W 16
`define PIN_W 10

`endif

// file: inc/stepper_pkg.sv
// types for the stepper phase sequencer
`include "stepper_consts.svh"
package stepper_pkg;
   typedef struct packed {
      logic [2:0] pos;
      logic step_prev;
      logic rst_prev;
      logic [3:0] windings;
      logic fault;
      logic [1:0] fault_kind;
      logic [`IRQ_W-1:0] irq_stat;
      logic [`IRQ_W-1:0] irq_mask;
      logic [`STEP_CNT_W-1:0] step_cnt;
      logic aw_held;
      logic [`AXI_AW-1:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } seq_state_t;
endpackage

// file: rtl/pin_sync.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sync_t;

   sync_t s_q;
   sync_t s_d;

   // first stage feeds only the second stage
   always_comb begin
      s_d.meta = d;
      s_d.sync = s_q.meta;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.sync;
endmodule

// file: rtl/stepper_phase_sequencer.sv
// stepper phase sequencer with protection latch and AXI4-Lite status/interrupt registers
// Summary of operation
// R1 - With edge select high the phase advances one step on each step clock rise only.
// R2 - Excitation select low gives full-step two-phase drive, high gives half-step drive.
// R3 - With edge select low the phase advances on every rise and every fall of the step clock.
// R4 - A low system reset pin, combined with power-on reset, holds the sequencer in reset.
// R5 - Leaving reset starts at the initial phase with winding one positive and two negative on.
// R6 - Enable low forces all four winding outputs off whatever the phase.
// R7 - Enable high again resumes from the held phase; enable never resets the sequence.
// R8 - Direction select low steps clockwise, high steps counterclockwise.
// R9 - The host keeps excitation and edge select still within 5 us of any step clock edge.
// R10 - While enable is low the sequencer is frozen and only reset has any effect; the code still latches faults then.
// R11 - Open terminal, overcurrent or overheat pulls the fault flag low, latched until reset.
// R12 - Outputs follow the four-state or eight-state unipolar pattern; mode switch keeps phase.
`timescale 1ns/100ps
`include "stepper_consts.svh"
module stepper_phase_sequencer (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic step_clock,
   input wire logic excitation_select,
   input wire logic clock_edge_select,
   input wire logic direction_select,
   input wire logic system_reset_low,
   input wire logic enable,
   input wire logic fault_open,
   input wire logic fault_overcurrent,
   input wire logic fault_overheat,
   input wire logic fault_flag_n_in,
   output logic winding_one_pos,
   output logic winding_one_neg,
   output logic winding_two_pos,
   output logic winding_two_neg,
   output logic fault_flag_n_out,
   output logic fault_flag_n_oe,
   output logic [1:0] fault_kind_level,
   output logic irq,
   input wire logic [`AXI_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`AXI_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   stepper_pkg::seq_state_t s_q;
   stepper_pkg::seq_state_t s_d;

   logic clk_s;
   logic exc_s;
   logic edge_sel_s;
   logic dir_s;
   logic rst_s;
   logic en_s;
   logic open_s;
   logic overcur_s;
   logic overheat_s;
   logic pin_s;
   logic rise_ev;
   logic fall_ev;
   logic run;
   logic step;
   logic fault_any;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic do_write;
   logic [`IRQ_W-1:0] irq_set;
   logic [`IRQ_W-1:0] irq_clr;

   // every pin, including the fault detectors, is asynchronous to clk
   pin_sync #(
      .WIDTH(`PIN_W)
   ) u_pin_sync (
      .clk(clk),
      .arst_n(arst_n),
      .d({step_clock, excitation_select, clock_edge_select, direction_select,
          system_reset_low, enable, fault_open, fault_overcurrent, fault_overheat,
          fault_flag_n_in}),
      .q({clk_s, exc_s, edge_sel_s, dir_s, rst_s, en_s, open_s, overcur_s, overheat_s,
          pin_s})
   );

   // unipolar pattern over eight half-step positions; even positions are two-phase
   function automatic logic [3:0] phase_pattern(input logic [2:0] p);
      logic [3:0] w;
      w = 4'h0;
      unique case (p)
         3'h0: w = 4'h9;
         3'h1: w = 4'h1;
         3'h2: w = 4'h5;
         3'h3: w = 4'h4;
         3'h4: w = 4'h6;
         3'h5: w = 4'h2;
         3'h6: w = 4'hA;
         3'h7: w = 4'h8;
      endcase
      return w;
   endfunction

   // full-step from an odd (one-phase) position realigns to the nearest even one
   function automatic logic [2:0] next_pos(input logic [2:0] p, input logic half,
                                           input logic ccw);
      logic [2:0] d;
      d = (half || p[0]) ? 3'h1 : 3'h2;
      return ccw ? 3'(p - d) : 3'(p + d);
   endfunction

   function automatic logic reg_hit(input logic [`AXI_AW-1:0] a);
      return (a == `REG_STATUS) || (a == `REG_IRQ_STAT) ||
             (a == `REG_IRQ_MASK) || (a == `REG_STEP_CNT);
   endfunction

   function automatic logic [31:0] read_word(input logic [`AXI_AW-1:0] a,
                                             input stepper_pkg::seq_state_t s,
                                             input logic en, input logic rs,
                                             input logic pin);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         `REG_STATUS: begin
            v[`ST_POS_LSB +: 3] = s.pos;
            v[`ST_FAULT] = s.fault;
            v[`ST_KIND_LSB +: 2] = s.fault_kind;
            v[`ST_ENABLE] = en;
            v[`ST_RESET] = !rs;
            v[`ST_PIN] = pin;
         end
         `REG_IRQ_STAT: v[`IRQ_W-1:0] = s.irq_stat;
         `REG_IRQ_MASK: v[`IRQ_W-1:0] = s.irq_mask;
         `REG_STEP_CNT: v[`STEP_CNT_W-1:0] = s.step_cnt;
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   assign rise_ev = clk_s && !s_q.step_prev;
   assign fall_ev = !clk_s && s_q.step_prev;
   // a stopped internal clock: stepping halts, but reset and the fault latch still act
   assign run = en_s && rst_s; // R10
   // mode bits are sampled at the same edge that steps, so they must be settled R9
   assign step = run && (rise_ev || (!edge_sel_s && fall_ev)); // R1 R3
   assign fault_any = open_s || overcur_s || overheat_s;

   assign awready = !s_q.aw_held && !s_q.bvalid;
   assign wready = !s_q.w_held && !s_q.bvalid;
   assign arready = !s_q.rvalid;
   assign aw_take = awvalid && awready;
   assign w_take = wvalid && wready;
   assign ar_take = arvalid && arready;
   assign do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;

   always_comb begin
      irq_set = '0;
      irq_set[`IRQ_STEP] = step;
      irq_set[`IRQ_FAULT] = rst_s && fault_any && !s_q.fault;
      irq_set[`IRQ_RELEASE] = rst_s && !s_q.rst_prev;
      irq_clr = '0;
      if (do_write && s_q.aw_addr == `REG_IRQ_STAT && s_q.w_strb[0]) begin
         irq_clr = s_q.w_data[`IRQ_W-1:0];
      end
   end

   always_comb begin
      s_d = s_q;
      // edge history keeps tracking while disabled so resuming makes no phantom step
      s_d.step_prev = clk_s;
      s_d.rst_prev = rst_s;
      if (!rst_s) begin
         s_d.pos = `POS_INIT; // R4 R5
         s_d.fault = 1'b0;
         s_d.fault_kind = `KIND_NONE;
      end else begin
         if (step) begin
            s_d.pos = next_pos(s_q.pos, exc_s, dir_s); // R2 R8 R12
            s_d.step_cnt = s_q.step_cnt + 1'b1;
         end
         if (!s_q.fault && fault_any) begin
            s_d.fault = 1'b1; // R11
            if (overheat_s) begin
               s_d.fault_kind = `KIND_OVERHEAT;
            end else if (overcur_s) begin
               s_d.fault_kind = `KIND_OVERCUR;
            end else begin
               s_d.fault_kind = `KIND_OPEN;
            end
         end
      end
      // gate at the output only, so the held phase is untouched by enable
      s_d.windings = (en_s && !s_d.fault) ? phase_pattern(s_d.pos) : 4'h0; // R6 R7 R12
      // set wins over a simultaneous write-one clear
      s_d.irq_stat = (s_q.irq_stat & ~irq_clr) | irq_set;
      if (aw_take) begin
         s_d.aw_held = 1'b1;
         s_d.aw_addr = awaddr;
      end
      if (w_take) begin
         s_d.w_held = 1'b1;
         s_d.w_data = wdata;
         s_d.w_strb = wstrb;
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      if (do_write) begin
         s_d.aw_held = 1'b0;
         s_d.w_held = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = reg_hit(s_q.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
         if (s_q.aw_addr == `REG_IRQ_MASK && s_q.w_strb[0]) begin
            s_d.irq_mask = s_q.w_data[`IRQ_W-1:0];
         end
      end
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (ar_take) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = read_word(araddr, s_q, en_s, rst_s, pin_s);
         s_d.rresp = reg_hit(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign winding_one_pos = s_q.windings[`WIND_W1P];
   assign winding_one_neg = s_q.windings[`WIND_W1N];
   assign winding_two_pos = s_q.windings[`WIND_W2P];
   assign winding_two_neg = s_q.windings[`WIND_W2N];
   // open drain: only ever pulls low
   assign fault_flag_n_out = 1'b0;
   assign fault_flag_n_oe = s_q.fault; // R11
   assign fault_kind_level = s_q.fault_kind;
   assign irq = |(s_q.irq_stat & s_q.irq_mask);
   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   chk_rise_only: assert property ( // R1
      (run && edge_sel_s && fall_ev) |=> $stable(s_q.pos))
      else $error("falling edge stepped in rising-edge mode");

   chk_full_even: assert property ( // R2
      (step && !exc_s) |=> !s_q.pos[0])
      else $error("full-step left the two-phase positions");

   chk_half_single: assert property ( // R2
      (step && exc_s && !dir_s) |=> s_q.pos == 3'($past(s_q.pos) + 3'h1))
      else $error("half-step did not move one position");

   chk_both_edges: assert property ( // R3
      (run && !edge_sel_s && fall_ev) |=> s_q.pos != $past(s_q.pos))
      else $error("falling edge ignored in both-edge mode");

   chk_reset_hold: assert property ( // R4
      !rst_s |=> s_q.pos == `POS_INIT)
      else $error("sequencer not held in reset");

   chk_init_phase: assert property ( // R5
      (!rst_s && en_s) |=> s_q.windings == `INIT_WIND)
      else $error("initial phase pattern wrong");

   chk_enable_off: assert property ( // R6
      !en_s |=> s_q.windings == 4'h0)
      else $error("windings driven while disabled");

   chk_resume_phase: assert property ( // R7
      (en_s && !s_q.fault && !fault_any) |=> s_q.windings == phase_pattern(s_q.pos))
      else $error("windings do not follow held phase");

   chk_ccw_dir: assert property ( // R8
      (step && exc_s && dir_s) |=> s_q.pos == 3'($past(s_q.pos) - 3'h1))
      else $error("counterclockwise step wrong");

   chk_disabled_hold: assert property ( // R10
      (!en_s && rst_s) ##1 (!en_s && rst_s) |-> $stable(s_q.pos) && $stable(s_q.step_cnt))
      else $error("sequencer moved while disabled");

   chk_fault_latch: assert property ( // R11
      (fault_any && rst_s) ##1 rst_s [*3] |-> s_q.fault && fault_flag_n_oe)
      else $error("fault not latched onto flag");

   chk_mode_keep: assert property ( // R12
      (run && $changed(exc_s) && !step) |=> $stable(s_q.pos))
      else $error("mode switch moved the phase");
endmodule

// file: dv/step_host.sv
// host controller model driving the step clock and the control pins
`timescale 1ns/100ps
module step_host (
   input wire logic clk,
   output logic step_clock,
   output logic excitation_select,
   output logic clock_edge_select,
   output logic direction_select,
   output logic system_reset_low,
   output logic enable
);
   initial begin
      step_clock = 1'b0;
      excitation_select = 1'b0;
      clock_edge_select = 1'b1;
      direction_select = 1'b0;
      system_reset_low = 1'b0;
      enable = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   // each level held at least 9 clk, well past what the pin sampler needs
   task automatic toggle();
      @(posedge clk);
      step_clock <= ~step_clock;
      hold(8);
   endtask
   // modes only move far from any step edge
   task automatic set_mode(input logic ex, input logic ed, input logic dir);
      hold(800);
      excitation_select <= ex;
      clock_edge_select <= ed;
      direction_select <= dir;
      hold(800);
   endtask
   task automatic set_ctl(input logic en, input logic rs);
      @(posedge clk);
      enable <= en;
      system_reset_low <= rs;
      hold(8);
   endtask
endmodule

// file: dv/stepper_phase_sequencer_tb.sv
// self-checking bench for the stepper phase sequencer
`timescale 1ns/100ps
`include "stepper_consts.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module stepper_phase_sequencer_tb;
   logic clk, arst_n, fault_pin, w1p, w1n, w2p, w2n, oe, fdrv, irq;
   logic step_clock, excitation_select, clock_edge_select, direction_select;
   logic system_reset_low, enable;
   logic [2:0] flt;
   logic [1:0] kind, bresp, rresp;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [3:0] w_now;
   logic [2:0] awprot, arprot;
   logic [3:0] wstrb;
   // only strobe bit 0 reaches the writable registers
   logic strb0 = 1'b1;
   logic [3:0] exp_w;
   logic [33:0] exp_bus;
   int num_errors = 0;
   int comparisons = 0;
   int seed = 32'h8ED8;
   logic [3:0] pat [8] = '{4'h9, 4'h1, 4'h5, 4'h4, 4'h6, 4'h2, 4'hA, 4'h8};
   logic [33:0] bus_q [$];
   logic [3:0] wind_q [$];
   logic [3:0] last_w = 4'h0;
   logic [3:0] prev_w = 4'h0;
   logic [2:0] pos = 3'h0;
   logic [15:0] nsteps = 16'h0;
   // open-drain fault wire with its pull-up
   assign fault_pin = oe ? fdrv : 1'b1;
   assign w_now = {w2n, w2p, w1n, w1p};
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   step_host host (.clk(clk), .step_clock(step_clock), .excitation_select(excitation_select),
      .clock_edge_select(clock_edge_select), .direction_select(direction_select),
      .system_reset_low(system_reset_low), .enable(enable));
   stepper_phase_sequencer dut (.clk(clk), .arst_n(arst_n), .step_clock(step_clock),
      .excitation_select(excitation_select), .clock_edge_select(clock_edge_select),
      .direction_select(direction_select), .system_reset_low(system_reset_low),
      .enable(enable), .fault_open(flt[0]), .fault_overcurrent(flt[1]),
      .fault_overheat(flt[2]), .fault_flag_n_in(fault_pin), .winding_one_pos(w1p),
      .winding_one_neg(w1n), .winding_two_pos(w2p), .winding_two_neg(w2n),
      .fault_flag_n_out(fdrv), .fault_flag_n_oe(oe), .fault_kind_level(kind), .irq(irq),
      .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   always @(posedge clk) begin
      if (arst_n && w_now !== prev_w) begin
         prev_w = w_now;
         // pop once: the compare macro names its expected value twice
         exp_w = wind_q.size() ? wind_q.pop_front() : 4'hX;
         `CHK(w_now, exp_w)
      end
      if (bvalid && bready) begin
         exp_bus = bus_q.pop_front();
         `CHK({bresp, 32'h0}, exp_bus)
      end
      if (rvalid && rready) begin
         exp_bus = bus_q.pop_front();
         `CHK({rresp, rdata}, exp_bus)
      end
   end
   task automatic expect_w(input logic [3:0] p);
      if (p !== last_w) wind_q.push_back(p);
      last_w = p;
   endtask
   // one edge of the step clock, with the expected phase move
   task automatic step();
      if ((!step_clock || !clock_edge_select) && enable) begin
         nsteps++;
         if (excitation_select || pos[0]) pos = direction_select ? pos - 3'h1 : pos + 3'h1;
         else pos = direction_select ? pos - 3'h2 : pos + 3'h2;
         expect_w(pat[pos]);
      end
      host.toggle();
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      bus_q.push_back({r, 32'h0});
      awaddr <= a;
      awprot <= 3'($random(seed));
      wdata <= d;
      wstrb <= {3'($random(seed)), strb0};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      bus_q.push_back({r, d});
      araddr <= a;
      arprot <= 3'($random(seed));
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
   endtask
   task automatic tdone(input string s);
      $display("test %s done", s);
   endtask
   task automatic finish_test();
      if (wind_q.size() != 0 || bus_q.size() != 0) num_errors++;
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      finish_test();
   end
   initial begin
      arst_n = 1'b0;
      flt = 3'h0;
      {awaddr, wdata, awvalid, wvalid, bready, araddr, arvalid, rready} = '0;
      {awprot, arprot, wstrb} = '0;
      expect_w(pat[0]);
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      host.hold(20);
      axi_read(`REG_STATUS, 32'h1C0, `RESP_OKAY);
      axi_read(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
      host.set_ctl(1'b1, 1'b1);
      axi_read(`REG_IRQ_STAT, 32'h4, `RESP_OKAY);
      axi_write(`REG_STATUS, 32'hFF, `RESP_OKAY);
      axi_read(`REG_STATUS, 32'h140, `RESP_OKAY);
      axi_read(8'h40, 32'h0, `RESP_SLVERR);
      axi_write(8'h44, 32'h1, `RESP_SLVERR);
      tdone("reset");
      repeat (4) begin
         host.set_mode(1'b0, 1'b1, 1'($random(seed)));
         repeat (4) step();
      end
      tdone("full step");
      host.set_mode(1'b1, 1'b0, 1'b0);
      repeat (5) step();
      host.set_mode(1'b0, 1'b0, 1'b1);
      repeat (3) step();
      host.set_mode(1'b1, 1'b1, 1'b1);
      repeat (4) step();
      tdone("half step");
      expect_w(4'h0);
      host.set_ctl(1'b0, 1'b1);
      repeat (2) step();
      expect_w(pat[pos]);
      host.set_ctl(1'b1, 1'b1);
      repeat (2) step();
      tdone("enable");
      axi_write(`REG_IRQ_STAT, 32'h7, `RESP_OKAY);
      axi_read(`REG_IRQ_STAT, 32'h0, `RESP_OKAY);
      axi_write(`REG_IRQ_MASK, 32'h1, `RESP_OKAY);
      repeat (2) step();
      `CHK(irq, 1'b1)
      axi_write(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
      `CHK(irq, 1'b0)
      axi_write(`REG_IRQ_MASK, 32'h1, `RESP_OKAY);
      `CHK(irq, 1'b1)
      axi_write(`REG_IRQ_STAT, 32'h1, `RESP_OKAY);
      `CHK(irq, 1'b0)
      strb0 = 1'b0;
      axi_write(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
      strb0 = 1'b1;
      axi_read(`REG_IRQ_MASK, 32'h1, `RESP_OKAY);
      tdone("irq");
      for (int k = 1; k < 4; k++) begin
         axi_write(`REG_IRQ_STAT, 32'h7, `RESP_OKAY);
         expect_w(4'h0);
         flt <= 3'(1 << (k - 1));
         host.hold(8);
         flt <= 3'h0;
         host.hold(4);
         `CHK(kind, 2'(k))
         `CHK(oe, 1'b1)
         axi_read(`REG_STATUS, {23'h0, 3'h1, 2'(k), 1'b1, pos}, `RESP_OKAY);
         axi_read(`REG_IRQ_STAT, 32'h2, `RESP_OKAY);
         pos = 3'h0;
         expect_w(pat[0]);
         host.set_ctl(1'b1, 1'b0);
         host.set_ctl(1'b1, 1'b1);
         `CHK(oe, 1'b0)
      end
      repeat (2) step();
      axi_read(`REG_STEP_CNT, {16'h0, nsteps}, `RESP_OKAY);
      tdone("fault");
      host.hold(10);
      finish_test();
   end
endmodule
